// >>> core/ius_flags.sv
// Upper status flags of the I2C controller with APB access and event interrupt
//
// Operation
// - Reserved bits 31..15 read zero, writes ignored
// - Bit 14 high only as slave-transmitter
// - Loopback forces slave direction flag low
// - START or STOP clears slave direction
// - Writing one clears slave direction flag; here the write has no effect, the flag follows core_slave_tx
// - Bit 13 sets when receiver sent nack
// - Nack flag clears: write one, reset
// - Bit 12 sets on START seen or made
// - Busy set while SCL low in reset
// - Busy clears on STOP seen or made
// - Busy clears: write one, module reset
// - Start request while busy gives restart
// - Bit 11 sets on unread byte overrun
// - Overrun holds transfer; shifting continues meanwhile
// - Overrun clears on data read, reset
// - Writing zero leaves clearable flags unchanged
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "ius_map.svh"

module ius_flags
  import ius_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // I2C bus lines as sampled
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  // Controller core, same clock
  input  wire logic        core_slave_tx,
  input  wire logic        core_rx_mode,
  input  wire logic        core_nack_sent,
  input  wire logic        core_start_made,
  input  wire logic        core_stop_made,
  // Start commands and nack drive to core
  output logic             start_cmd,
  output logic             restart_cmd,
  output logic             nack_drive,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address compare for one register word
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    addr_is = (a[11:2] == off[11:2]);
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic                 scl_m_q;
  logic                 scl_s_q;
  logic                 scl_p_q;
  logic                 sda_m_q;
  logic                 sda_s_q;
  logic                 sda_p_q;
  logic [3:0]           mode_q;
  logic [3:0]           mode_d;
  logic                 slave_transmit_direction_q;
  logic                 slave_transmit_direction_d;
  logic                 nsent_q;
  logic                 nsent_d;
  logic                 busy_q;
  logic                 busy_d;
  logic                 ovr_q;
  logic                 ovr_d;
  ius_byte_t            shift_q;
  ius_byte_t            rxdata_q;
  ius_byte_t            rxdata_d;
  logic                 unread_q;
  logic                 unread_d;
  logic [3:0]           bitcnt_q;
  ius_rx_e              rx_q;
  ius_rx_e              rx_d;
  logic [`IUS_EV_W-1:0] ev_q;
  logic [`IUS_EV_W-1:0] ev_d;
  logic [`IUS_EV_W-1:0] en_q;
  logic [31:0]          prdata_q;
  logic                 pready_q;
  logic                 pslverr_q;
  logic                 start_q;
  logic                 restart_q;
  logic                 nackdrv_q;
  logic                 irq_q;

  // ----------------------------------------------------------------
  // Bus line synchronisers and edge detection
  // ----------------------------------------------------------------
  // Two stages per line, then one history stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  // Conditions on the bus
  wire scl_rise   = scl_s_q & ~scl_p_q;
  wire start_seen = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire stop_seen  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  wire start_any  = start_seen | core_start_made;
  wire stop_any   = stop_seen | core_stop_made;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire setup    = psel & ~penable;
  wire acc      = psel & penable & pready_q;
  wire wr       = acc & pwrite;
  wire rd       = acc & ~pwrite;
  wire hit_st   = addr_is(paddr, `IUS_OFF_STATUS);
  wire hit_rx   = addr_is(paddr, `IUS_OFF_RXDATA);
  wire hit_md   = addr_is(paddr, `IUS_OFF_MODE);
  wire hit_evs  = addr_is(paddr, `IUS_OFF_EVSTAT);
  wire hit_evc  = addr_is(paddr, `IUS_OFF_EVCLR);
  wire hit_ev   = addr_is(paddr, `IUS_OFF_EVEN);
  wire mapped   = hit_st | hit_rx | hit_md | hit_evs | hit_evc | hit_ev;
  wire wr_st    = wr & hit_st;
  wire wr_md    = wr & hit_md;
  wire rd_rx    = rd & hit_rx;

  // Write-one clear strobes; a written zero touches nothing
  wire clr_slave_transmit_direction = wr_st & pwdata[`IUS_ST_SLAVE_TRANSMIT_DIRECTION];
  wire clr_ns   = wr_st & pwdata[`IUS_ST_NACKSENT];
  wire clr_busy = wr_st & pwdata[`IUS_ST_BUSY];
  // Module run control: low holds the controller in reset
  wire run      = mode_q[`IUS_MD_RUN];
  wire loopback = mode_q[`IUS_MD_LOOP];
  wire run_off  = wr_md & ~pwdata[`IUS_MD_RUN];
  wire held     = ~run | run_off;
  // Start request from software
  wire start_req = wr_md & pwdata[`IUS_MD_START] & pwdata[`IUS_MD_RUN];

  // ----------------------------------------------------------------
  // Receive framing
  // ----------------------------------------------------------------
  // Byte completes on the eighth clock, then the ack clock
  wire byte_done = (rx_q == IUS_RX_SHIFT) & scl_rise & (bitcnt_q == `IUS_BITS_BYTE - 4'h1);
  wire ack_clk   = (rx_q == IUS_RX_ACK) & scl_rise;
  wire nack_mode = mode_q[`IUS_MD_NACK];
  wire overrun   = byte_done & (unread_q & ~rd_rx);
  wire self_nack = ack_clk & nack_mode;

  // Framing state selection
  always_comb begin
    rx_d = rx_q;
    case (rx_q)
      IUS_RX_IDLE:  if (start_any && core_rx_mode && run) begin
        rx_d = IUS_RX_SHIFT;
      end
      IUS_RX_SHIFT: if (byte_done) begin
        rx_d = IUS_RX_ACK;
      end
      IUS_RX_ACK:   if (ack_clk) begin
        rx_d = IUS_RX_SHIFT;
      end
      default:      rx_d = IUS_RX_IDLE;
    endcase
    if (held || stop_any || !core_rx_mode) begin
      rx_d = IUS_RX_IDLE;
    end
  end

  // Shift register keeps taking bits even during overrun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q     <= IUS_RX_IDLE;
      bitcnt_q <= 4'h0;
      shift_q  <= 8'h00;
    end else begin
      rx_q <= rx_d;
      if (rx_q != IUS_RX_SHIFT) begin
        bitcnt_q <= 4'h0;
      end else if (scl_rise) begin
        bitcnt_q <= bitcnt_q + 4'h1;
      end
      if (rx_q == IUS_RX_SHIFT && scl_rise) begin
        shift_q <= {shift_q[6:0], sda_s_q};
      end
    end
  end

  // Data register load, held back while old byte unread
  always_comb begin
    rxdata_d = rxdata_q;
    unread_d = unread_q;
    if (rd_rx) begin
      unread_d = 1'b0;
    end
    if (byte_done && !overrun) begin
      rxdata_d = {shift_q[6:0], sda_s_q};
      unread_d = 1'b1;
    end else if (rd_rx && ovr_q) begin
      rxdata_d = shift_q;
      unread_d = 1'b1;
    end
    if (held) begin
      unread_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Next values, set events placed after clears
  always_comb begin
    slave_transmit_direction_d = slave_transmit_direction_q;
    if (clr_slave_transmit_direction || start_any || stop_any) begin
      slave_transmit_direction_d = 1'b0;
    end
    if (core_slave_tx && !start_any && !stop_any) begin
      slave_transmit_direction_d = 1'b1;
    end
    if (loopback || !core_slave_tx || held) begin
      slave_transmit_direction_d = 1'b0;
    end

    nsent_d = nsent_q;
    if (clr_ns) begin
      nsent_d = 1'b0;
    end
    if (core_nack_sent || self_nack) begin
      nsent_d = 1'b1;
    end
    if (held) begin
      nsent_d = 1'b0;
    end

    busy_d = busy_q;
    if (clr_busy || stop_any) begin
      busy_d = 1'b0;
    end
    if (start_any) begin
      busy_d = 1'b1;
    end
    if (held) begin
      busy_d = ~scl_s_q;
    end

    ovr_d = ovr_q;
    if (rd_rx) begin
      ovr_d = 1'b0;
    end
    if (overrun) begin
      ovr_d = 1'b1;
    end
    if (held) begin
      ovr_d = 1'b0;
    end
  end

  // Mode register; start request is a one-shot
  always_comb begin
    mode_d = mode_q;
    mode_d[`IUS_MD_START] = 1'b0;
    if (wr_md) begin
      mode_d = pwdata[3:0];
      mode_d[`IUS_MD_START] = 1'b0;
    end
  end

  // Flag and mode registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q   <= `IUS_MODE_RST;
      slave_transmit_direction_q   <= 1'b0;
      nsent_q  <= 1'b0;
      busy_q   <= 1'b0;
      ovr_q    <= 1'b0;
      rxdata_q <= 8'h00;
      unread_q <= 1'b0;
    end else begin
      mode_q   <= mode_d;
      slave_transmit_direction_q   <= slave_transmit_direction_d;
      nsent_q  <= nsent_d;
      busy_q   <= busy_d;
      ovr_q    <= ovr_d;
      rxdata_q <= rxdata_d;
      unread_q <= unread_d;
    end
  end

  // ----------------------------------------------------------------
  // Start commands and nack drive
  // ----------------------------------------------------------------
  // Busy bus turns a start request into a restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q   <= 1'b0;
      restart_q <= 1'b0;
      nackdrv_q <= 1'b0;
    end else begin
      start_q   <= start_req & ~busy_q;
      restart_q <= start_req & busy_q;
      nackdrv_q <= (rx_d == IUS_RX_ACK) & nack_mode;
    end
  end

  // ----------------------------------------------------------------
  // Event interrupt
  // ----------------------------------------------------------------
  // Sticky events; a new event wins over its clear
  wire [`IUS_EV_W-1:0] ev_set = {
    stop_any & busy_q,
    start_any & ~busy_q,
    (core_nack_sent | self_nack) & ~nsent_q,
    overrun & ~ovr_q
  };
  wire [`IUS_EV_W-1:0] ev_clr = (wr & hit_evc) ? pwdata[`IUS_EV_W-1:0] : {`IUS_EV_W{1'b0}};

  assign ev_d = (ev_q & ~ev_clr) | ev_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_q  <= `IUS_EV_RST;
      en_q  <= `IUS_EV_RST;
      irq_q <= 1'b0;
    end else begin
      ev_q  <= ev_d;
      if (wr && hit_ev) begin
        en_q <= pwdata[`IUS_EV_W-1:0];
      end
      irq_q <= |(ev_d & (wr && hit_ev ? pwdata[`IUS_EV_W-1:0] : en_q));
    end
  end

  // ----------------------------------------------------------------
  // APB read path and answer
  // ----------------------------------------------------------------
  // Status word; upper reserved bits stay zero
  wire [31:0] status_word = {
    17'h00000,
    slave_transmit_direction_q, nsent_q, busy_q, ovr_q,
    11'h000
  };

  // Read mux, unmapped reads return zero
  wire [31:0] rd_word =
    hit_st  ? status_word :
    hit_rx  ? {24'h000000, rxdata_q} :
    hit_md  ? {28'h0000000, mode_q} :
    hit_evs ? {{(32-`IUS_EV_W){1'b0}}, ev_q} :
    hit_ev  ? {{(32-`IUS_EV_W){1'b0}}, en_q} :
    32'h00000000;

  // Answer in the first access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) begin
        prdata_q <= pwrite ? 32'h00000000 : rd_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign start_cmd   = start_q;
  assign restart_cmd = restart_q;
  assign nack_drive  = nackdrv_q;
  assign irq         = irq_q;

endmodule

// >>> core/ius_map.svh
// Register offsets, field positions, reset values and receive framing of the status flag block
`ifndef IUS_MAP_SVH
`define IUS_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define IUS_OFF_STATUS   12'h008
`define IUS_OFF_RXDATA   12'h018
`define IUS_OFF_MODE     12'h024
`define IUS_OFF_EVSTAT   12'h040
`define IUS_OFF_EVCLR    12'h044
`define IUS_OFF_EVEN     12'h048

// ----------------------------------------------------------------
// Status register field positions
// ----------------------------------------------------------------
`define IUS_ST_SLAVE_TRANSMIT_DIRECTION      14
`define IUS_ST_NACKSENT  13
`define IUS_ST_BUSY      12
`define IUS_ST_OVERRUN   11

// ----------------------------------------------------------------
// Mode register field positions and reset value
// ----------------------------------------------------------------
`define IUS_MD_RUN       0
`define IUS_MD_START     1
`define IUS_MD_LOOP      2
`define IUS_MD_NACK      3
`define IUS_MODE_RST     4'h0

// ----------------------------------------------------------------
// Event bits: 0 overrun, 1 nack sent, 2 busy set, 3 bus free
// ----------------------------------------------------------------
`define IUS_EV_W         4
`define IUS_EV_RST       4'h0

// ----------------------------------------------------------------
// Receive framing
// ----------------------------------------------------------------
`define IUS_BITS_BYTE    4'h8

`endif

// >>> core/ius_pkg.sv
// Types shared by the status flag block
package ius_pkg;

  // Receive framing states
  typedef enum logic [1:0] {
    IUS_RX_IDLE  = 2'b00,
    IUS_RX_SHIFT = 2'b01,
    IUS_RX_ACK   = 2'b10
  } ius_rx_e;

  typedef logic [7:0] ius_byte_t;

endpackage

// >>> verification/ius_bus_model.sv
// Behavioural far-side bus agent driving clock and data lines
`timescale 1ns/1ps
module ius_bus_model (
  // Bus lines toward the block
  output logic scl,
  output logic sda
);
  // Idle bus: both lines pulled up, clock stands still
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // Data falls while clock high, then clock goes low
  task automatic start_cond();
    #10; // Off the sampling edge
    sda = 1'b1;
    #80;
    scl = 1'b1;
    #80;
    sda = 1'b0;
    #80;
    scl = 1'b0;
    #80;
  endtask

  // Eight bits MSB first, ninth slot left to the pull-up
  task automatic send_byte(input logic [7:0] b);
    logic [8:0] s;
    s = {b, 1'b1};
    #10; // Off the sampling edge
    for (int i = 8; i >= 0; i--) begin
      sda = s[i];
      #80;
      scl = 1'b1;
      #160;
      scl = 1'b0;
      #80;
    end
  endtask

  // Data rises while clock high
  task automatic stop_cond();
    #10; // Off the sampling edge
    sda = 1'b0;
    #80;
    scl = 1'b1;
    #80;
    sda = 1'b1;
    #80;
  endtask
endmodule

// >>> verification/ius_flags_checker.sv
// Port-level checks for the upper status flag block
`timescale 1ns/1ps
module ius_flags_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Core side
  input wire logic        core_slave_tx,
  input wire logic        start_cmd,
  input wire logic        restart_cmd,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Status read and start request write, seen at the answer edge
  wire st_rd  = pready && !pwrite && paddr[11:2] == 10'h002;
  wire go_wr  = psel && penable && pready && pwrite && paddr[11:2] == 10'h009
                && pwdata[1:0] == 2'h3;
  wire cmd    = start_cmd || restart_cmd;

  property p_ready;
    psel && !penable |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no answer after setup");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("answer held too long");
  property p_err;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("error answer malformed");
  property p_wr_zero;
    pready && pwrite |-> prdata == 32'h0;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("read data on write");
  property p_resv;
    st_rd |-> prdata[31:15] == 17'h0 && prdata[10:0] == 11'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved status bits set");
  property p_slave_transmit_direction;
    st_rd && prdata[14] |-> $past(core_slave_tx, 2) || $past(core_slave_tx, 3);
  endproperty
  a_slave_transmit_direction: assert property (p_slave_transmit_direction) else $error("slave direction without cause");
  property p_start;
    go_wr |-> ##[1:2] cmd;
  endproperty
  a_start: assert property (p_start) else $error("start request lost");
  property p_cmd_src;
    cmd |-> ($past(go_wr) || $past(go_wr, 2)) && !(start_cmd && restart_cmd) ##1 !cmd;
  endproperty
  a_cmd_src: assert property (p_cmd_src) else $error("start command malformed");

  c_err: cover property (pslverr);
  c_restart: cover property (restart_cmd);
  c_slave_transmit_direction: cover property (st_rd && prdata[14]);
  c_irq: cover property (irq);
endmodule

bind ius_flags ius_flags_checker chk_u (
  .pclk          (pclk),
  .presetn       (presetn),
  .psel          (psel),
  .penable       (penable),
  .pwrite        (pwrite),
  .paddr         (paddr),
  .pwdata        (pwdata),
  .prdata        (prdata),
  .pready        (pready),
  .pslverr       (pslverr),
  .core_slave_tx (core_slave_tx),
  .start_cmd     (start_cmd),
  .restart_cmd   (restart_cmd),
  .irq           (irq)
);

// >>> verification/tb.sv
// Self-checking bench for the upper status flag block
`timescale 1ns/1ps
`include "ius_map.svh"
module tb;
  import ius_pkg::*;
  // Bench signals
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        scl, sda, start_cmd, restart_cmd, nack_drive, irq;
  logic        slv_tx, rx_mode, nack_snt, st_made, sp_made;
  logic [7:0]  b0, b1, b2;
  int          n_fail = 0;
  int          checks = 0;
  int          n_st = 0;
  int          n_rs = 0;
  int          n_nd = 0;
  int          seed = 32'h6474;

  ius_flags dut_u (
    .pclk            (pclk),
    .presetn         (presetn),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .scl_in          (scl),
    .sda_in          (sda),
    .core_slave_tx   (slv_tx),
    .core_rx_mode    (rx_mode),
    .core_nack_sent  (nack_snt),
    .core_start_made (st_made),
    .core_stop_made  (sp_made),
    .start_cmd       (start_cmd),
    .restart_cmd     (restart_cmd),
    .nack_drive      (nack_drive),
    .irq             (irq)
  );
  ius_bus_model bus_u (
    .scl (scl),
    .sda (sda)
  );

  // Clock and command pulse counters
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    if (start_cmd === 1'b1) n_st++;
    if (restart_cmd === 1'b1) n_rs++;
    if (nack_drive === 1'b1) n_nd++;
  end

  // Expected status word from the four flags
  function automatic logic [31:0] st(input logic sd, nk, bb, ov);
    return {17'h0, sd, nk, bb, ov, 11'h0};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer, held until the answer edge; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic nack_pulse();
    @(posedge pclk);
    nack_snt <= 1'b1;
    @(posedge pclk);
    nack_snt <= 1'b0;
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #1000000;
    n_fail++;
    final_report();
  end

  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {slv_tx, rx_mode, nack_snt, st_made, sp_made} = '0;
    presetn = 1'b0;
    wt(3);
    presetn <= 1'b1;
    rdc("status", `IUS_OFF_STATUS, st(0, 0, 0, 0));
    rdc("mode", `IUS_OFF_MODE, 32'h0);
    rdc("evstat", `IUS_OFF_EVSTAT, 32'h0);
    rdc("unmapped", 12'h00c, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    #10 bus_u.scl = 1'b0;
    wt(8);
    rdc("status", `IUS_OFF_STATUS, st(0, 0, 1, 0));
    #10 bus_u.scl = 1'b1;
    wt(8);
    rdc("status", `IUS_OFF_STATUS, st(0, 0, 0, 0));
    $display("test reset done");
    wr(`IUS_OFF_MODE, 32'h1);
    slv_tx <= 1'b1;
    wt(4);
    rdc("status", `IUS_OFF_STATUS, st(1, 0, 0, 0));
    wr(`IUS_OFF_MODE, 32'h5);
    rdc("status", `IUS_OFF_STATUS, st(0, 0, 0, 0));
    wr(`IUS_OFF_MODE, 32'h1);
    rdc("status", `IUS_OFF_STATUS, st(1, 0, 0, 0));
    slv_tx <= 1'b0;
    wt(2);
    rdc("status", `IUS_OFF_STATUS, st(0, 0, 0, 0));
    $display("test slave direction done");
    wr(`IUS_OFF_EVEN, 32'hf);
    bus_u.start_cond();
    wt(8);
    rdc("status", `IUS_OFF_STATUS, st(0, 0, 1, 0));
    rdc("evstat", `IUS_OFF_EVSTAT, 32'h4);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`IUS_OFF_STATUS, $random(seed) & 32'hffff87ff);
    rdc("status", `IUS_OFF_STATUS, st(0, 0, 1, 0));
    wr(`IUS_OFF_MODE, 32'h3);
    wt(2);
    chk("restart", 32'h1, n_rs);
    chk("start", 32'h0, n_st);
    wr(`IUS_OFF_EVEN, 32'h0);
    wt(2);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`IUS_OFF_STATUS, st(0, 0, 1, 0));
    rdc("status", `IUS_OFF_STATUS, st(0, 0, 0, 0));
    @(posedge pclk) st_made <= 1'b1;
    @(posedge pclk) st_made <= 1'b0;
    wt(2);
    rdc("status", `IUS_OFF_STATUS, st(0, 0, 1, 0));
    bus_u.stop_cond();
    wt(8);
    rdc("status", `IUS_OFF_STATUS, st(0, 0, 0, 0));
    rdc("evstat", `IUS_OFF_EVSTAT, 32'hc);
    wr(`IUS_OFF_EVEN, 32'hf);
    wt(2);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`IUS_OFF_EVCLR, 32'hf);
    wt(2);
    chk("irq", 32'h0, {31'h0, irq});
    rdc("evstat", `IUS_OFF_EVSTAT, 32'h0);
    wr(`IUS_OFF_MODE, 32'h3);
    wt(2);
    chk("start", 32'h1, n_st);
    @(posedge pclk) sp_made <= 1'b1;
    @(posedge pclk) sp_made <= 1'b0;
    wt(2);
    $display("test bus busy done");
    nack_pulse();
    wt(2);
    rdc("status", `IUS_OFF_STATUS, st(0, 1, 0, 0));
    wr(`IUS_OFF_STATUS, st(0, 1, 0, 0));
    rdc("status", `IUS_OFF_STATUS, st(0, 0, 0, 0));
    fork
      wr(`IUS_OFF_STATUS, st(0, 1, 0, 0));
      begin
        wt(1);
        nack_pulse();
      end
    join
    rdc("status", `IUS_OFF_STATUS, st(0, 1, 0, 0));
    wr(`IUS_OFF_MODE, 32'h0);
    rdc("status", `IUS_OFF_STATUS, st(0, 0, 0, 0));
    wr(`IUS_OFF_MODE, 32'h1);
    nack_pulse();
    presetn <= 1'b0;
    wt(2);
    presetn <= 1'b1;
    rdc("status", `IUS_OFF_STATUS, st(0, 0, 0, 0));
    rdc("mode", `IUS_OFF_MODE, 32'h0);
    $display("test nack sent done");
    wr(`IUS_OFF_MODE, 32'h1);
    rx_mode <= 1'b1;
    b0 = $random(seed);
    b1 = $random(seed);
    b2 = $random(seed);
    bus_u.start_cond();
    bus_u.send_byte(b0);
    wt(8);
    rdc("rxdata", `IUS_OFF_RXDATA, {24'h0, b0});
    bus_u.send_byte(b1);
    bus_u.send_byte(b2);
    wt(8);
    rdc("status", `IUS_OFF_STATUS, st(0, 0, 1, 1));
    rdc("evstat", `IUS_OFF_EVSTAT, 32'h5);
    rdc("rxdata", `IUS_OFF_RXDATA, {24'h0, b1});
    rdc("status", `IUS_OFF_STATUS, st(0, 0, 1, 0));
    rdc("rxdata", `IUS_OFF_RXDATA, {24'h0, b2});
    bus_u.send_byte(b0);
    bus_u.send_byte(b1);
    wt(8);
    rdc("status", `IUS_OFF_STATUS, st(0, 0, 1, 1));
    wr(`IUS_OFF_MODE, 32'h0);
    rdc("status", `IUS_OFF_STATUS, st(0, 0, 1, 0));
    bus_u.stop_cond();
    wt(8);
    rdc("status", `IUS_OFF_STATUS, st(0, 0, 0, 0));
    $display("test receive overrun done");
    wr(`IUS_OFF_MODE, 32'h9);
    bus_u.start_cond();
    bus_u.send_byte(b2);
    wt(8);
    chk("nack drive cycles", 32'h8, n_nd);
    rdc("status", `IUS_OFF_STATUS, st(0, 1, 1, 0));
    rdc("rxdata", `IUS_OFF_RXDATA, {24'h0, b2});
    $display("test nack mode done");
    final_report();
  end
endmodule
